// >>> uctl_pkg.sv
// constants and types shared by the serial control block
`default_nettype none
package uctl_pkg;
  // ----------------
  // register byte offsets
  // ----------------
  localparam logic [11:0] OFS_CTRL_ONE = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_DIVISOR = 12'h00C;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  // ----------------
  // serial_control_one fields
  // ----------------
  localparam int C1_GLOBAL_EN = 7;
  localparam int C1_DATA_LEN = 6;
  localparam int C1_PAR_EN = 5;
  localparam int C1_PAR_TYPE = 4;
  localparam int C1_STOP_CNT = 3;
  localparam int C1_BREAK = 2;
  localparam int C1_NINTH_RX = 1;
  localparam int C1_NINTH_TX = 0;
  // ----------------
  // serial_control_two fields
  // ----------------
  localparam int C2_TX_EN = 7;
  localparam int C2_RX_EN = 6;
  localparam int C2_SPEED = 5;
  localparam int C2_ADDR_DET = 4;
  localparam int C2_WAKE_EN = 3;
  localparam int C2_RX_IE = 2;
  localparam int C2_TRANSMITTER_IDLE_FLAG_IE = 1;
  localparam int C2_TEMPTY_IE = 0;
  // ----------------
  // reset values and timing counts
  // ----------------
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] OS_LOW_LAST = 6'h3F;
  localparam logic [5:0] OS_HIGH_LAST = 6'h0F;
  localparam logic [5:0] OS_LOW_HALF = 6'h1F;
  localparam logic [5:0] OS_HIGH_HALF = 6'h07;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  // ----------------
  // state types
  // ----------------
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} uctl_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} uctl_rx_state_t;
endpackage
`default_nettype wire

// >>> uctl_rate_if.sv
// link between the control logic and the rate divider
`default_nettype none
interface uctl_rate_if;
  logic [7:0] divisor;
  logic restart;
  logic tick;
  modport gen (input divisor, input restart, output tick);
  modport user (output divisor, output restart, input tick);
endinterface
`default_nettype wire

// >>> uctl_rate_gen.sv
// free running rate divider producing the oversampling tick
`default_nettype none
module uctl_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  uctl_rate_if.gen rate
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } uctl_rg_st_t;

  uctl_rg_st_t s_r;
  uctl_rg_st_t s_nxt;

  // ----------------
  // count down, reload on terminal count
  // ----------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (rate.restart) begin
      s_nxt.cnt = rate.divisor;
    end else if (s_r.cnt == 8'h00) begin
      s_nxt.cnt = rate.divisor; // [RULE6]
      s_nxt.tick = 1'b1; // [RULE21]
    end else begin
      s_nxt.cnt = 8'(s_r.cnt - 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rate.tick = s_r.tick;
endmodule
`default_nettype wire

// >>> uctl_top.sv
// serial transceiver control, data register and rate setup
//
// Notes on behaviour
// [RULE1] transmit enable low aborts, resets, floats TX
// [RULE2] transmitter drives TX only when both enabled
// [RULE3] receive enable low aborts, resets receiver
// [RULE4] receiver owns RX only when both enabled
// [RULE5] bit rate is clock over 64(N+1) or 16(N+1)
// [RULE6] free running 8-bit divider, N from 0 to 255
// [RULE7] address bit set marks address, may interrupt
// [RULE8] address bit clear discards word, no interrupt
// [RULE9] clock stopped plus wake: RX fall requests wake
// [RULE10] no wake request while clock runs
// [RULE11] wake disabled: RX falls ignored while stopped
// [RULE12] receive enable routes overrun, available onto request
// [RULE13] idle enable routes transmitter idle onto request
// [RULE14] empty enable routes transmit empty onto request
// [RULE15] one 8-bit data register both directions
// [RULE16] start, 8 or 9 data, parity, stop bits
// [RULE17] default frame eight bits, no parity, one stop
// [RULE18] LSB first, both directions share one rate
// [RULE19] global disable empties, resets flags, keeps setup
// [RULE20] length select picks 8 or 9, ninth separate
// [RULE21] divider ticks 16 or 64 times per bit
//
// Chosen here: register access over APB and the placing of the registers.
`default_nettype none
module uctl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin_in,
  input wire logic clock_stopped,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic rx_pin_claim,
  output logic wake_request,
  output logic serial_irq
);
  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] divisor;
    logic [7:0] rx_data;
    logic [7:0] tx_hold;
    logic tx_empty, tx_idle, rx_avail, overrun, frame_err, parity_err;
    uctl_pkg::uctl_tx_state_t txs;
    logic [5:0] tx_ph;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_par, tx_line, tx_oe;
    uctl_pkg::uctl_rx_state_t rxs;
    logic [5:0] rx_ph;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_par, rx_s1, rx_s2, rx_prev, stop_s1, stop_s2, wake, irq, claim;
    logic [31:0] prdata;
    logic pready, pslverr;
  } uctl_st_t;

  uctl_st_t s_r;
  uctl_st_t s_nxt;
  uctl_rate_if rate ();

  uctl_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .rate(rate)
  );

  logic setup, access, gen_on, tx_act, rx_act, rx_ninth, addr_bit, rd_err;
  logic [5:0] os_last;
  logic [5:0] os_half;
  logic [3:0] last_bit;
  logic [7:0] rx_byte;
  logic [31:0] rd_word;

  assign setup = psel & ~penable;
  assign access = psel & penable & s_r.pready;
  assign gen_on = s_r.ctrl_one[uctl_pkg::C1_GLOBAL_EN];
  assign tx_act = gen_on & s_r.ctrl_two[uctl_pkg::C2_TX_EN]; // [RULE2]
  assign rx_act = gen_on & s_r.ctrl_two[uctl_pkg::C2_RX_EN]; // [RULE4]
  assign os_last = s_r.ctrl_two[uctl_pkg::C2_SPEED] ? uctl_pkg::OS_HIGH_LAST
                                                    : uctl_pkg::OS_LOW_LAST; // [RULE5]
  assign os_half = s_r.ctrl_two[uctl_pkg::C2_SPEED] ? uctl_pkg::OS_HIGH_HALF
                                                    : uctl_pkg::OS_LOW_HALF;
  assign last_bit = s_r.ctrl_one[uctl_pkg::C1_DATA_LEN] ? uctl_pkg::LAST_BIT_NINE
                                                       : uctl_pkg::LAST_BIT_EIGHT; // [RULE20]
  assign rx_byte = s_r.ctrl_one[uctl_pkg::C1_DATA_LEN] ? s_r.rx_sh[7:0] : s_r.rx_sh[8:1];
  assign rx_ninth = s_r.rx_sh[8];
  assign addr_bit = s_r.ctrl_one[uctl_pkg::C1_DATA_LEN] ? rx_ninth : rx_byte[7]; // [RULE7]
  assign rate.divisor = s_r.divisor;
  assign rate.restart = ~gen_on | s_r.stop_s2; // [RULE19]

  // ----------------
  // read decode
  // ----------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      uctl_pkg::OFS_CTRL_ONE: rd_word = {24'h00_0000, s_r.ctrl_one[7:1], 1'b0};
      uctl_pkg::OFS_CTRL_TWO: rd_word = {24'h00_0000, s_r.ctrl_two};
      uctl_pkg::OFS_DATA: rd_word = {24'h00_0000, s_r.rx_data}; // [RULE15]
      uctl_pkg::OFS_DIVISOR: rd_word = {24'h00_0000, s_r.divisor};
      uctl_pkg::OFS_STATUS: rd_word = {25'h000_0000, s_r.parity_err, s_r.frame_err,
                                       s_r.overrun, s_r.rxs == uctl_pkg::RX_IDLE,
                                       s_r.rx_avail, s_r.tx_idle, s_r.tx_empty};
      default: rd_err = 1'b1;
    endcase
  end

  // ----------------
  // next state
  // ----------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rx_s1 = rx_pin_in;
    s_nxt.rx_s2 = s_r.rx_s1;
    s_nxt.rx_prev = s_r.rx_s2;
    s_nxt.stop_s1 = clock_stopped;
    s_nxt.stop_s2 = s_r.stop_s1;
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata = rd_word;
      s_nxt.pslverr = rd_err;
    end
    if (!tx_act) begin
      s_nxt.txs = uctl_pkg::TX_IDLE; // [RULE1]
      s_nxt.tx_oe = 1'b0; // [RULE1]
      s_nxt.tx_line = 1'b1;
      s_nxt.tx_empty = 1'b1; // [RULE1]
      s_nxt.tx_idle = 1'b1;
    end
    if (!rx_act) begin
      s_nxt.rxs = uctl_pkg::RX_IDLE; // [RULE3]
      s_nxt.rx_avail = 1'b0; // [RULE3]
      s_nxt.overrun = 1'b0;
      s_nxt.claim = 1'b0;
    end
    if (access && !s_r.pslverr) begin
      if (pwrite) begin
        case (paddr)
          uctl_pkg::OFS_CTRL_ONE: begin
            s_nxt.ctrl_one = {pwdata[7:2], s_r.ctrl_one[uctl_pkg::C1_NINTH_RX], pwdata[0]};
          end
          uctl_pkg::OFS_CTRL_TWO: s_nxt.ctrl_two = pwdata[7:0];
          uctl_pkg::OFS_DIVISOR: s_nxt.divisor = pwdata[7:0]; // [RULE6]
          uctl_pkg::OFS_DATA: begin
            if (s_nxt.tx_empty) begin
              s_nxt.tx_hold = pwdata[7:0]; // [RULE15]
              s_nxt.tx_empty = 1'b0;
              s_nxt.tx_idle = 1'b0;
            end
          end
          default: ;
        endcase
      end else if (paddr == uctl_pkg::OFS_DATA) begin
        s_nxt.rx_avail = 1'b0;
        s_nxt.overrun = 1'b0;
        s_nxt.frame_err = 1'b0;
        s_nxt.parity_err = 1'b0;
      end
    end
    // ----------------
    // transmitter
    // ----------------
    if (tx_act) begin
      s_nxt.tx_oe = 1'b1; // [RULE2]
      case (s_r.txs)
        uctl_pkg::TX_IDLE: begin
          s_nxt.tx_line = 1'b1;
          if (!s_nxt.tx_empty && rate.tick) begin // start on a tick: full start bit
            s_nxt.tx_sh = {s_r.ctrl_one[uctl_pkg::C1_NINTH_TX], s_nxt.tx_hold}; // [RULE20]
            s_nxt.tx_par = (s_r.ctrl_one[uctl_pkg::C1_DATA_LEN]
                            ? ^{s_r.ctrl_one[uctl_pkg::C1_NINTH_TX], s_nxt.tx_hold}
                            : ^s_nxt.tx_hold) ^ s_r.ctrl_one[uctl_pkg::C1_PAR_TYPE];
            s_nxt.tx_empty = 1'b1; // [RULE14]
            s_nxt.tx_idle = 1'b0;
            s_nxt.tx_line = 1'b0; // [RULE16]
            s_nxt.tx_ph = 6'h00;
            s_nxt.txs = uctl_pkg::TX_START;
          end else if (s_nxt.tx_empty) begin
            s_nxt.tx_idle = 1'b1; // [RULE13]
          end
        end
        uctl_pkg::TX_START, uctl_pkg::TX_DATA, uctl_pkg::TX_PARITY, uctl_pkg::TX_STOP: begin
          if (rate.tick) begin
            s_nxt.tx_ph = 6'(s_r.tx_ph + 6'h01);
            if (s_r.tx_ph == os_last) begin
              s_nxt.tx_ph = 6'h00;
              case (s_r.txs)
                uctl_pkg::TX_START: begin
                  s_nxt.txs = uctl_pkg::TX_DATA;
                  s_nxt.tx_line = s_r.tx_sh[0]; // [RULE18]
                  s_nxt.tx_bit = 4'h0;
                end
                uctl_pkg::TX_DATA: begin
                  s_nxt.tx_sh = {1'b0, s_r.tx_sh[8:1]};
                  s_nxt.tx_line = s_r.tx_sh[1]; // [RULE18]
                  s_nxt.tx_bit = 4'(s_r.tx_bit + 4'h1);
                  if (s_r.tx_bit == last_bit) begin
                    s_nxt.tx_bit = 4'h0;
                    if (s_r.ctrl_one[uctl_pkg::C1_PAR_EN]) begin
                      s_nxt.txs = uctl_pkg::TX_PARITY;
                      s_nxt.tx_line = s_r.tx_par; // [RULE16]
                    end else begin
                      s_nxt.txs = uctl_pkg::TX_STOP;
                      s_nxt.tx_line = 1'b1;
                    end
                  end
                end
                uctl_pkg::TX_PARITY: begin
                  s_nxt.txs = uctl_pkg::TX_STOP;
                  s_nxt.tx_line = 1'b1;
                  s_nxt.tx_bit = 4'h0;
                end
                default: begin
                  if (s_r.ctrl_one[uctl_pkg::C1_STOP_CNT] && s_r.tx_bit == 4'h0) begin
                    s_nxt.tx_bit = 4'h1; // [RULE16]
                  end else begin
                    s_nxt.txs = uctl_pkg::TX_IDLE;
                  end
                end
              endcase
            end
          end
        end
        default: s_nxt.txs = uctl_pkg::TX_IDLE;
      endcase
    end
    // ----------------
    // receiver
    // ----------------
    if (rx_act) begin
      s_nxt.claim = 1'b1; // [RULE4]
      case (s_r.rxs)
        uctl_pkg::RX_IDLE: begin
          if (!s_r.rx_s2 && s_r.rx_prev && !s_r.stop_s2) begin
            s_nxt.rxs = uctl_pkg::RX_START;
            s_nxt.rx_ph = 6'h00;
            s_nxt.rx_sh = 9'h000;
          end
        end
        uctl_pkg::RX_START: begin
          if (rate.tick) begin
            s_nxt.rx_ph = 6'(s_r.rx_ph + 6'h01);
            if (s_r.rx_ph == os_half) begin
              s_nxt.rx_ph = 6'h00;
              s_nxt.rx_bit = 4'h0;
              s_nxt.rxs = s_r.rx_s2 ? uctl_pkg::RX_IDLE : uctl_pkg::RX_DATA;
            end
          end
        end
        uctl_pkg::RX_DATA, uctl_pkg::RX_PARITY, uctl_pkg::RX_STOP: begin
          if (rate.tick) begin
            s_nxt.rx_ph = 6'(s_r.rx_ph + 6'h01);
            if (s_r.rx_ph == os_last) begin
              s_nxt.rx_ph = 6'h00;
              case (s_r.rxs)
                uctl_pkg::RX_DATA: begin
                  s_nxt.rx_sh = {s_r.rx_s2, s_r.rx_sh[8:1]}; // [RULE18]
                  s_nxt.rx_bit = 4'(s_r.rx_bit + 4'h1);
                  if (s_r.rx_bit == last_bit) begin
                    s_nxt.rxs = s_r.ctrl_one[uctl_pkg::C1_PAR_EN] ? uctl_pkg::RX_PARITY
                                                                 : uctl_pkg::RX_STOP;
                  end
                end
                uctl_pkg::RX_PARITY: begin
                  s_nxt.rx_par = s_r.rx_s2;
                  s_nxt.rxs = uctl_pkg::RX_STOP;
                end
                default: begin
                  s_nxt.rxs = uctl_pkg::RX_IDLE;
                  if (!(s_r.ctrl_two[uctl_pkg::C2_ADDR_DET] && !addr_bit)) begin // [RULE8]
                    if (s_nxt.rx_avail) begin
                      s_nxt.overrun = 1'b1;
                    end else begin
                      s_nxt.rx_data = rx_byte; // [RULE15]
                      s_nxt.ctrl_one[uctl_pkg::C1_NINTH_RX] = rx_ninth; // [RULE20]
                      s_nxt.rx_avail = 1'b1; // [RULE7]
                      s_nxt.frame_err = ~s_r.rx_s2;
                      s_nxt.parity_err = s_r.ctrl_one[uctl_pkg::C1_PAR_EN] &
                        (s_r.rx_par != ((s_r.ctrl_one[uctl_pkg::C1_DATA_LEN]
                                         ? ^{rx_ninth, rx_byte} : ^rx_byte)
                                        ^ s_r.ctrl_one[uctl_pkg::C1_PAR_TYPE]));
                    end
                  end
                end
              endcase
            end
          end
        end
        default: s_nxt.rxs = uctl_pkg::RX_IDLE;
      endcase
    end
    // ----------------
    // wake request
    // ----------------
    if (!s_r.stop_s2) begin
      s_nxt.wake = 1'b0; // [RULE10]
    end else if (s_r.ctrl_two[uctl_pkg::C2_WAKE_EN] && !s_r.rx_s2 && s_r.rx_prev) begin
      s_nxt.wake = 1'b1; // [RULE9] [RULE11]
    end
    // ----------------
    // global disable
    // ----------------
    if (!s_nxt.ctrl_one[uctl_pkg::C1_GLOBAL_EN]) begin
      s_nxt.ctrl_two[uctl_pkg::C2_TX_EN] = 1'b0; // [RULE19]
      s_nxt.ctrl_two[uctl_pkg::C2_RX_EN] = 1'b0; // [RULE19]
      s_nxt.ctrl_one[uctl_pkg::C1_BREAK] = 1'b0;
      s_nxt.rx_avail = 1'b0;
      s_nxt.overrun = 1'b0;
      s_nxt.frame_err = 1'b0;
      s_nxt.parity_err = 1'b0;
      s_nxt.tx_empty = 1'b1;
      s_nxt.tx_idle = 1'b1;
    end
    // ----------------
    // shared interrupt request
    // ----------------
    s_nxt.irq =
      (s_r.ctrl_two[uctl_pkg::C2_RX_IE] & (s_nxt.rx_avail | s_nxt.overrun)) | // [RULE12]
      (s_r.ctrl_two[uctl_pkg::C2_RX_IE] & s_nxt.wake) | // [RULE9]
      (s_r.ctrl_two[uctl_pkg::C2_TRANSMITTER_IDLE_FLAG_IE] & s_nxt.tx_idle) | // [RULE13]
      (s_r.ctrl_two[uctl_pkg::C2_TEMPTY_IE] & s_nxt.tx_empty); // [RULE14]
  end

  // ----------------
  // state register
  // ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.ctrl_one <= uctl_pkg::CTRL_ONE_RST; // [RULE17]
      s_r.ctrl_two <= uctl_pkg::CTRL_TWO_RST;
      s_r.divisor <= uctl_pkg::DIVISOR_RST;
      s_r.rx_data <= uctl_pkg::DATA_RST;
      s_r.tx_empty <= 1'b1;
      s_r.tx_idle <= 1'b1;
      s_r.tx_line <= 1'b1;
      s_r.rx_s1 <= 1'b1;
      s_r.rx_s2 <= 1'b1;
      s_r.rx_prev <= 1'b1;
      s_r.txs <= uctl_pkg::TX_IDLE;
      s_r.rxs <= uctl_pkg::RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign tx_pin_out = s_r.tx_line;
  assign tx_pin_oe = s_r.tx_oe;
  assign rx_pin_claim = s_r.claim;
  assign wake_request = s_r.wake;
  assign serial_irq = s_r.irq;
endmodule
`default_nettype wire

// >>> uctl_top_asserts.sv
// port checker for the serial control block
`default_nettype none
module uctl_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic clock_stopped,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic rx_pin_claim,
  input wire logic wake_request,
  input wire logic serial_irq
);
  // ----------------
  // shadow of control writes
  // ----------------
  logic g_r, tx_r, rx_r, hs_r, tq_r;
  logic [2:0] ie_r;
  logic [7:0] n_r;
  int cnt_r;
  int blen;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  assign blen = (int'(n_r) + 1) * (hs_r ? 16 : 64);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {g_r, tx_r, rx_r, hs_r, tq_r, ie_r, n_r} <= '0;
      cnt_r <= 0;
    end else begin
      tq_r <= tx_pin_out;
      cnt_r <= (tx_pin_out != tq_r) ? 1 : cnt_r + 1;
      if (wr && paddr == uctl_pkg::OFS_CTRL_ONE) begin
        g_r <= pwdata[7];
        if (!pwdata[7]) {tx_r, rx_r} <= 2'h0;
      end
      if (wr && paddr == uctl_pkg::OFS_CTRL_TWO) begin
        {tx_r, rx_r, hs_r} <= pwdata[7:5];
        ie_r <= pwdata[2:0];
      end
      if (wr && paddr == uctl_pkg::OFS_DIVISOR) n_r <= pwdata[7:0];
    end
  end
  sequence off_wr;
    wr && paddr == uctl_pkg::OFS_CTRL_ONE && !pwdata[7];
  endsequence
  sequence tx_rise;
    $rose(tx_pin_out) && tx_pin_oe && $past(tx_pin_oe);
  endsequence
  // ----------------
  // assertions
  // ----------------
  tx_drive_a: assert property ($stable(g_r && tx_r) [*2] |-> tx_pin_oe == (g_r && tx_r))
    else $error("tx drive enable mismatch");
  rx_claim_a: assert property ($stable(g_r && rx_r) [*2] |-> rx_pin_claim == (g_r && rx_r))
    else $error("rx claim mismatch");
  tx_idle_a: assert property (!tx_pin_oe [*2] |-> tx_pin_out)
    else $error("tx line not idle while released");
  wake_src_a: assert property ($rose(wake_request) |-> $past(clock_stopped, 2) || $past(clock_stopped, 3))
    else $error("wake raised while clock runs");
  wake_clr_a: assert property (!clock_stopped [*5] |-> !wake_request)
    else $error("wake held while clock runs");
  irq_mask_a: assert property ((ie_r == 3'h0) [*3] |-> !serial_irq)
    else $error("irq with all enables off");
  bit_time_a: assert property (tx_rise |-> cnt_r % blen == 0)
    else $error("tx bit length off");
  global_off_a: assert property (off_wr |-> ##[1:3] (!tx_pin_oe && !rx_pin_claim))
    else $error("pins kept after global disable");
endmodule
bind uctl_top uctl_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .clock_stopped(clock_stopped), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
  .rx_pin_claim(rx_pin_claim), .wake_request(wake_request), .serial_irq(serial_irq));
`default_nettype wire

// >>> uctl_remote.sv
// remote serial device on the tx and rx lines
`default_nettype none
module uctl_remote (
  input wire logic pclk,
  input wire logic tx_line,
  input wire logic tx_oe,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line;
  assign line = tx_oe ? tx_line : 1'b1;
  initial rx_line = 1'b1;
  task automatic send(input logic [8:0] d, input int nb, input int bl);
    rx_line <= 1'b0;
    repeat (bl) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bl) @(posedge pclk);
    end
    rx_line <= 1'b1;
    repeat (bl) @(posedge pclk);
  endtask
  task automatic fall;
    rx_line <= 1'b0;
    repeat (8) @(posedge pclk);
    rx_line <= 1'b1;
  endtask
  task automatic recv(input int nb, input int bl, output logic [8:0] d, output logic ok);
    int t;
    d = '0;
    t = 0;
    while (line && t < 20000) begin
      @(posedge pclk);
      t++;
    end
    repeat (bl / 2) @(posedge pclk);
    ok = !line && t < 20000;
    for (int i = 0; i < nb; i++) begin
      repeat (bl) @(posedge pclk);
      d[i] = line;
    end
    repeat (bl) @(posedge pclk);
    ok = ok && line;
  endtask
endmodule
`default_nettype wire

// >>> test_uart_control_and_baud_generator.sv
// self-checking bench for the serial control block
`default_nettype none
module test_uart_control_and_baud_generator;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, clock_stopped, e;
  logic tx_pin_out, tx_pin_oe, rx_pin_claim, wake_request, serial_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int errors, checks_done;
  uctl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin_in(rx_line), .clock_stopped(clock_stopped),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_claim(rx_pin_claim),
    .wake_request(wake_request), .serial_irq(serial_irq));
  uctl_remote u_remote (.pclk(pclk), .tx_line(tx_pin_out), .tx_oe(tx_pin_oe),
    .rx_line(rx_line));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ----------------
  // bus and compare tasks
  // ----------------
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    if (t >= 50) begin
      chk("pready", 32'h1, 32'h0);
      test_done;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask
  task automatic wait_st(input int b);
    int t;
    t = 0;
    do begin
      apb(1'b0, uctl_pkg::OFS_STATUS, 32'h0, q, e);
      t++;
    end while (q[b] !== 1'b1 && t < 3000);
    if (t >= 3000) begin
      chk("status wait", 32'h1, 32'h0);
      test_done;
    end
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset;
    chk("tx line", 32'h1, {31'h0, tx_pin_out});
    chk("tx drive", 32'h0, {31'h0, tx_pin_oe});
    rd(uctl_pkg::OFS_CTRL_ONE, 32'h0, "ctrl one");
    rd(uctl_pkg::OFS_STATUS, 32'hB, "status");
    apb(1'b0, 12'h014, 32'h0, q, e);
    chk("unmapped", 32'h1, {31'h0, e});
    $display("test reset done");
  endtask
  task automatic t_tx;
    logic [8:0] d;
    logic ok;
    wr(uctl_pkg::OFS_CTRL_ONE, 8'h80);
    wr(uctl_pkg::OFS_DIVISOR, 8'h01);
    wr(uctl_pkg::OFS_CTRL_TWO, 8'hA0);
    chk("tx drive", 32'h1, {31'h0, tx_pin_oe});
    wr(uctl_pkg::OFS_DATA, 8'hA5);
    u_remote.recv(8, 32, d, ok);
    chk("tx byte", 32'h2A5, {22'h0, ok, d});
    wait_st(1);
    wr(uctl_pkg::OFS_DIVISOR, 8'h00);
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h80);
    wr(uctl_pkg::OFS_CTRL_ONE, 8'hC1);
    wr(uctl_pkg::OFS_DATA, 8'h3C);
    u_remote.recv(9, 64, d, ok);
    chk("tx nine", 32'h33C, {22'h0, ok, d});
    wait_st(1);
    $display("test tx done");
  endtask
  task automatic t_rx;
    wr(uctl_pkg::OFS_CTRL_ONE, 8'h80);
    wr(uctl_pkg::OFS_DIVISOR, 8'h01);
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h64);
    chk("rx claim", 32'h1, {31'h0, rx_pin_claim});
    u_remote.send(9'h05A, 8, 32);
    wait_st(2);
    chk("rx irq", 32'h1, {31'h0, serial_irq});
    rd(uctl_pkg::OFS_DATA, 32'h5A, "rx byte");
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h74);
    u_remote.send(9'h012, 8, 32);
    repeat (20) @(posedge pclk);
    chk("data word irq", 32'h0, {31'h0, serial_irq});
    u_remote.send(9'h093, 8, 32);
    wait_st(2);
    chk("addr irq", 32'h1, {31'h0, serial_irq});
    rd(uctl_pkg::OFS_DATA, 32'h93, "addr byte");
    $display("test rx done");
  endtask
  task automatic t_abort;
    wr(uctl_pkg::OFS_CTRL_TWO, 8'hA0);
    wr(uctl_pkg::OFS_DATA, 8'h00);
    repeat (100) @(posedge pclk);
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h20);
    repeat (3) @(posedge pclk);
    chk("abort line", 32'h1, {30'h0, tx_pin_oe, tx_pin_out});
    rd(uctl_pkg::OFS_STATUS, 32'hB, "abort status");
    $display("test abort done");
  endtask
  task automatic t_wake;
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h08);
    clock_stopped <= 1'b1;
    repeat (4) @(posedge pclk);
    u_remote.fall();
    repeat (4) @(posedge pclk);
    chk("wake", 32'h1, {31'h0, wake_request});
    clock_stopped <= 1'b0;
    repeat (6) @(posedge pclk);
    u_remote.fall();
    repeat (6) @(posedge pclk);
    chk("wake running", 32'h0, {31'h0, wake_request});
    wr(uctl_pkg::OFS_CTRL_TWO, 8'h00);
    clock_stopped <= 1'b1;
    repeat (4) @(posedge pclk);
    u_remote.fall();
    repeat (6) @(posedge pclk);
    chk("wake off", 32'h0, {31'h0, wake_request});
    clock_stopped <= 1'b0;
    repeat (6) @(posedge pclk);
    $display("test wake done");
  endtask
  task automatic t_global;
    wr(uctl_pkg::OFS_CTRL_TWO, 8'hE0);
    wr(uctl_pkg::OFS_CTRL_ONE, 8'h00);
    rd(uctl_pkg::OFS_CTRL_TWO, 32'h20, "ctrl two kept");
    rd(uctl_pkg::OFS_DIVISOR, 32'h1, "divisor kept");
    rd(uctl_pkg::OFS_STATUS, 32'hB, "off status");
    $display("test global done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    clock_stopped = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_abort();
    t_wake();
    t_global();
    test_done();
  end
endmodule
`default_nettype wire
